// File: verilog/vac_core.sv
// valve amplifier command logic: inputs, preset select, ramp, mode
// mapping, dither and 1 kHz pwm for solenoids a and b, status outputs
// assumes converter samples on core_clk, discrete pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
module vac_core
  import vac_pkg::*;
#(
  parameter int PWM_PERIOD = vac_pkg::PWM_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [vac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [vac_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [7:0] din_pin,
  input wire logic fault_pin,
  input wire logic [9:0] adc_a,
  input wire logic [9:0] adc_b,
  output logic sol_a_pwm,
  output logic sol_b_pwm,
  output logic dout_err,
  output logic dout_sol_b,
  output logic led_green,
  output logic led_yellow,
  output logic led_red,
  output logic nvm_store
);
  import vac_pkg::*;

  // two-stage synchronisers for pins
  logic [7:0] din_meta_ff;
  logic [7:0] din_sync_ff;
  logic fault_meta_ff;
  logic fault_sync_ff;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_meta_ff <= 8'h03;
      din_sync_ff <= 8'h03;
      fault_meta_ff <= 1'b0;
      fault_sync_ff <= 1'b0;
    end
    else
    begin
      din_meta_ff <= din_pin;
      din_sync_ff <= din_meta_ff;
      fault_meta_ff <= fault_pin;
      fault_sync_ff <= fault_meta_ff;
    end
  end

  // input polarity and meaning
  wire dis_a_n = din_sync_ff[0];
  wire dis_b_n = din_sync_ff[1];
  wire in_dis_a = ~dis_a_n;
  wire in_dis_b = ~dis_b_n;
  wire in_enable = din_sync_ff[2];
  wire in_sel_b = din_sync_ff[3];
  wire in_ramp_off = din_sync_ff[4];
  wire [2:0] fix_code = din_sync_ff[7:5];

  // configuration registers
  vac_mode_t mode_ff;
  logic [10:0] imin_ff;
  logic [10:0] imax_ff;
  logic [7:0] dfreq_ff;
  logic [7:0] dlvl_ff;
  logic [15:0] ramp_time_ff;
  logic nvm_store_ff;
  logic [9:0] fix_ff [8];
  // write decode
  wire wr_mode = reg_wr && reg_addr == REG_MODE;
  wire wr_imin = reg_wr && reg_addr == REG_IMIN;
  wire wr_imax = reg_wr && reg_addr == REG_IMAX;
  wire wr_dfreq = reg_wr && reg_addr == REG_DFREQ;
  wire wr_dlvl = reg_wr && reg_addr == REG_DLVL;
  wire wr_ramp = reg_wr && reg_addr == REG_RAMP;
  wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
  wire wr_fix = reg_wr && reg_addr[3] == REG_FIX_BASE[3];
  // write values clamped to the allowed ranges
  wire [10:0] w_cur = reg_wdata[10:0];
  wire [10:0] nxt_imin = (w_cur > IMIN_LIM) ? IMIN_LIM : w_cur;
  wire [10:0] imax_cap = (w_cur > IMAX_LIM) ? IMAX_LIM : w_cur;
  wire [10:0] nxt_imax = (imax_cap < imin_ff) ? imin_ff : imax_cap;
  wire [7:0] w_b = reg_wdata[7:0];
  wire [7:0] nxt_dfreq = (w_b < DFREQ_LO) ? DFREQ_LO :
                         (w_b > DFREQ_HI) ? DFREQ_HI : w_b;
  wire [7:0] nxt_dlvl = (w_b > DLVL_LIM) ? DLVL_LIM : w_b;

  // parameter registers, defaults at reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= MODE_SINGLE;
      imin_ff <= IMIN_RST;
      imax_ff <= IMAX_RST;
      dfreq_ff <= DFREQ_RST;
      dlvl_ff <= DLVL_RST;
      ramp_time_ff <= RAMP_RST;
      nvm_store_ff <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        mode_ff <= vac_mode_t'(reg_wdata[1:0]);
      if (wr_imin)
        imin_ff <= nxt_imin;
      if (wr_imax)
        imax_ff <= nxt_imax;
      else if (wr_imin && nxt_imin > imax_ff)
        imax_ff <= nxt_imin; // keeps imax at or above imin
      if (wr_dfreq)
        dfreq_ff <= nxt_dfreq;
      if (wr_dlvl)
        dlvl_ff <= nxt_dlvl;
      if (wr_ramp)
        ramp_time_ff <= reg_wdata;
      nvm_store_ff <= wr_ctrl && reg_wdata[CTRL_STORE_BIT];
    end
  end
  // fixed preset store, slot zero means external
  assign fix_ff[0] = FIX_RST;
  genvar k;
  generate
    for (k = 1; k < 8; k++)
    begin : g_fix
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          fix_ff[k] <= FIX_RST;
        else if (wr_fix && reg_addr[2:0] == 3'(k))
          fix_ff[k] <= reg_wdata[9:0];
      end
    end
  endgenerate

  // preset source selection
  logic [9:0] target [2];
  assign target[0] = (fix_code != 3'h0) ? fix_ff[fix_code] : adc_a;
  assign target[1] = (fix_code != 3'h0) ? fix_ff[fix_code] : adc_b;
  // ramp time base: one microsecond tick and step divider
  logic [5:0] us_cnt_ff;
  logic [15:0] step_cnt_ff;
  wire us_tick = us_cnt_ff == 6'(US_CYC - 1);
  wire step_tick = us_tick && (step_cnt_ff + 16'h0001 >= ramp_time_ff);
  wire ramp_bypass = in_ramp_off || ramp_time_ff == 16'h0000;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      us_cnt_ff <= 6'h00;
      step_cnt_ff <= 16'h0000;
    end
    else
    begin
      us_cnt_ff <= us_tick ? 6'h00 : us_cnt_ff + 6'h01;
      if (step_tick)
        step_cnt_ff <= 16'h0000;
      else if (us_tick)
        step_cnt_ff <= step_cnt_ff + 16'h0001;
    end
  end
  // dither oscillator: phase flips at twice the dither frequency
  logic [NCO_W-1:0] nco_ff;
  logic dith_hi_ff;
  wire [NCO_W-1:0] nco_sum = nco_ff + NCO_W'({dfreq_ff, 1'b0});
  wire nco_wrap = nco_sum >= NCO_W'(CLK_HZ);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nco_ff <= '0;
      dith_hi_ff <= 1'b0;
    end
    else
    begin
      nco_ff <= nco_wrap ? nco_sum - NCO_W'(CLK_HZ) : nco_sum;
      if (nco_wrap)
        dith_hi_ff <= ~dith_hi_ff;
    end
  end
  // pwm period counter, duty loaded at period end
  logic [15:0] pwm_cnt_ff;
  wire pwm_end = pwm_cnt_ff == 16'(PWM_PERIOD - 1);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_cnt_ff <= 16'h0000;
    else
      pwm_cnt_ff <= pwm_end ? 16'h0000 : pwm_cnt_ff + 16'h0001;
  end

  // mode mapping from ramped presets to channel fraction and select
  logic [9:0] ramp_ff [2];
  logic [9:0] frac [2];
  logic [1:0] chan_on;
  wire [9:0] p_a = ramp_ff[0];
  wire upper = p_a >= PRE_MID;
  // end points reach 1023 so full deflection lands exactly on imax
  wire [9:0] up_frac = {p_a[8:0], p_a[8]}; // (p-512)*2, top end 1023
  wire [9:0] dn_frac = {~p_a[8:0], ~p_a[8]}; // (511-p)*2, zero end 1023
  always_comb
  begin
    frac[0] = p_a;
    frac[1] = p_a;
    chan_on = 2'b00;
    unique case (mode_ff)
      MODE_SINGLE:
      begin
        chan_on = in_sel_b ? 2'b10 : 2'b01;
      end
      MODE_SPLIT, MODE_BIPOLAR:
      begin
        frac[0] = up_frac;
        frac[1] = dn_frac;
        chan_on = upper ? 2'b01 : 2'b10;
      end
      MODE_DUAL:
      begin
        frac[1] = ramp_ff[1];
        chan_on = 2'b11;
      end
    endcase
  end

  wire [1:0] dis = {in_dis_b, in_dis_a};
  wire [1:0] drive_en = chan_on & ~dis & {2{in_enable}};
  wire [10:0] span = imax_ff - imin_ff;
  wire [6:0] dith_half = dlvl_ff[7:1];
  logic [10:0] cur_cmd [2];
  logic [15:0] duty_ff [2];
  logic pwm_ff [2];
  // per solenoid: ramp, current scaling, dither, pwm
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_chan
      wire [20:0] prod = span * frac[c];
      wire [10:0] scaled = (frac[c] == PRE_TOP) ? span : prod[20:10];
      wire [11:0] cur_up = {1'b0, cur_cmd[c]} + {5'h00, dith_half};
      wire [11:0] cur_dn = (cur_cmd[c] > {4'h0, dith_half}) ?
                           {1'b0, cur_cmd[c] - {4'h0, dith_half}} : 12'h000;
      wire [11:0] cur_dith = !drive_en[c] ? 12'h000 :
                             dith_hi_ff ? cur_up : cur_dn;
      wire [31:0] duty_full = (32'(cur_dith) * 32'(PWM_PERIOD)) /
                              32'(CUR_FS_MA);
      wire step_up = ramp_ff[c] < target[c];
      wire step_dn = ramp_ff[c] > target[c];
      wire [9:0] nxt_ramp = ramp_bypass ? target[c] :
                            !step_tick ? ramp_ff[c] :
                            step_up ? ramp_ff[c] + 10'h001 :
                            step_dn ? ramp_ff[c] - 10'h001 : ramp_ff[c];
      assign cur_cmd[c] = drive_en[c] ? imin_ff + scaled : 11'h000;
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ramp_ff[c] <= 10'h000;
          duty_ff[c] <= 16'h0000;
          pwm_ff[c] <= 1'b0;
        end
        else
        begin
          ramp_ff[c] <= nxt_ramp;
          if (pwm_end || !drive_en[c])
            duty_ff[c] <= drive_en[c] ? duty_full[15:0] : 16'h0000;
          pwm_ff[c] <= pwm_cnt_ff < duty_ff[c];
        end
      end
    end
  endgenerate

  // status outputs and indicators
  logic err_ff;
  logic sol_b_ff;
  logic [DATA_W-1:0] rdata_ff;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_ff <= 1'b0;
      sol_b_ff <= 1'b0;
    end
    else
    begin
      err_ff <= fault_sync_ff;
      sol_b_ff <= drive_en[1];
    end
  end

  // read mux, answer stands in the cycle after the strobe
  wire [DATA_W-1:0] status_word = 16'(
    {drive_en[1], drive_en[0], err_ff, din_sync_ff}) << ST_DIN_LSB;
  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (reg_addr[3])
      rd_mux = {6'h00, fix_ff[reg_addr[2:0]]};
    else
      unique case (reg_addr[2:0])
        REG_MODE[2:0]: rd_mux = {14'h0000, mode_ff};
        REG_IMIN[2:0]: rd_mux = {5'h00, imin_ff};
        REG_IMAX[2:0]: rd_mux = {5'h00, imax_ff};
        REG_DFREQ[2:0]: rd_mux = {8'h00, dfreq_ff};
        REG_DLVL[2:0]: rd_mux = {8'h00, dlvl_ff};
        REG_RAMP[2:0]: rd_mux = ramp_time_ff;
        REG_CTRL[2:0]: rd_mux = '0;
        REG_STATUS[2:0]: rd_mux = status_word;
      endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else
      rdata_ff <= reg_rd ? rd_mux : '0;
  end

  assign reg_rdata = rdata_ff;
  assign sol_a_pwm = pwm_ff[0];
  assign sol_b_pwm = pwm_ff[1];
  assign dout_err = err_ff;
  assign dout_sol_b = sol_b_ff;
  assign led_green = 1'b1;
  assign led_yellow = sol_b_ff;
  assign led_red = err_ff;
  assign nvm_store = nvm_store_ff;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_dis_a_gate: assert property (!din_sync_ff[0] |-> !drive_en[0])
    else $error("solenoid a driven while disabled");
  a_dis_b_gate: assert property (!din_sync_ff[1] |-> !drive_en[1])
    else $error("solenoid b driven while disabled");
  a_enable_zero: assert property (!in_enable |-> cur_cmd[0] == 11'h000
    && cur_cmd[1] == 11'h000)
    else $error("current commanded without enable");
  a_duty_off: assert property (!drive_en[0] ##1 !drive_en[0]
    |=> !sol_a_pwm)
    else $error("pwm active on disabled output");
  a_ramp_bypass: assert property (in_ramp_off |=>
    ramp_ff[0] == $past(target[0]))
    else $error("ramp not bypassed");
  a_fixed_sel: assert property (fix_code != 3'h0 && ramp_bypass |=>
    ramp_ff[0] == $past(fix_ff[fix_code]))
    else $error("fixed preset not followed");
  a_single_sel: assert property (mode_ff == MODE_SINGLE && drive_en[1]
    |-> in_sel_b && !drive_en[0])
    else $error("solenoid b selected wrongly in mode one");
  a_split_sel: assert property (mode_ff == MODE_SPLIT
    && p_a >= PRE_MID |-> !drive_en[1])
    else $error("solenoid b on in upper half");
  a_imin_floor: assert property (drive_en[0] |->
    cur_cmd[0] >= imin_ff && cur_cmd[0] <= imax_ff)
    else $error("current outside imin to imax");
  a_err_out: assert property (fault_sync_ff |=> dout_err && led_red)
    else $error("error output missing");
  a_sol_b_out: assert property ($rose(drive_en[1]) |=> dout_sol_b
    && led_yellow)
    else $error("solenoid b status missing");
  a_pwm_wrap: assert property (pwm_end |=> pwm_cnt_ff == 16'h0000)
    else $error("pwm period wrong");
endmodule : vac_core
`default_nettype wire

// File: verilog/vac_pkg.sv
// constants of the valve amplifier command logic
// assumes a single 40 MHz core clock and a plain register port
package vac_pkg;
  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_IMIN = 4'h1;
  localparam logic [3:0] REG_IMAX = 4'h2;
  localparam logic [3:0] REG_DFREQ = 4'h3;
  localparam logic [3:0] REG_DLVL = 4'h4;
  localparam logic [3:0] REG_RAMP = 4'h5;
  localparam logic [3:0] REG_CTRL = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_FIX_BASE = 4'h8;
  // field positions
  localparam int CTRL_STORE_BIT = 0;
  localparam int ST_DIN_LSB = 0;
  localparam int ST_ERR_BIT = 8;
  localparam int ST_DRV_A_BIT = 9;
  localparam int ST_DRV_B_BIT = 10;
  // operating modes
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_SPLIT = 2'b01,
    MODE_BIPOLAR = 2'b10,
    MODE_DUAL = 2'b11
  } vac_mode_t;
  // current settings in mA
  localparam logic [10:0] IMIN_RST = 11'h096;
  localparam logic [10:0] IMIN_LIM = 11'h3B6;
  localparam logic [10:0] IMAX_RST = 11'h2BC;
  localparam logic [10:0] IMAX_LIM = 11'h708;
  localparam int CUR_FS_MA = 2000;
  // dither in Hz and mA, then ramp time and fixed preset resets
  localparam logic [7:0] DFREQ_RST = 8'h64;
  localparam logic [7:0] DFREQ_LO = 8'h14;
  localparam logic [7:0] DFREQ_HI = 8'hFA;
  localparam logic [7:0] DLVL_RST = 8'h64;
  localparam logic [7:0] DLVL_LIM = 8'hC8;
  localparam logic [15:0] RAMP_RST = 16'h0000;
  localparam logic [9:0] FIX_RST = 10'h000;
  // preset scale, 10-bit converter
  localparam logic [9:0] PRE_MID = 10'h200;
  localparam logic [9:0] PRE_TOP = 10'h3FF;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int PWM_HZ = 1000;
  localparam int PWM_CYC = CLK_HZ / PWM_HZ;
  localparam int US_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int NCO_W = 27;
endpackage : vac_pkg

// File: dv/vac_valve_model.sv
// solenoid pair model: integrates each coil's pwm on-time over a window
// assumes pwm outputs sampled on core_clk; go is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module vac_valve_model #(
  parameter int PERIOD = 400
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sol_a_pwm,
  input wire logic sol_b_pwm,
  input wire logic meas_go,
  output logic meas_done,
  output logic [15:0] on_a,
  output logic [15:0] on_b
);
  logic [15:0] left_ff;
  // count high cycles of each coil over one pwm period
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_ff <= 16'h0000;
      on_a <= 16'h0000;
      on_b <= 16'h0000;
      meas_done <= 1'b0;
    end
    else
    begin
      meas_done <= (left_ff == 16'h0001);
      if (meas_go)
      begin
        left_ff <= 16'(PERIOD);
        on_a <= 16'h0000;
        on_b <= 16'h0000;
      end
      else if (left_ff != 16'h0000)
      begin
        left_ff <= left_ff - 16'h0001;
        on_a <= on_a + 16'(sol_a_pwm);
        on_b <= on_b + 16'(sol_b_pwm);
      end
    end
  end
endmodule : vac_valve_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the valve amplifier command logic
// assumes vac_core and the coil model; pwm period shortened to 400
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import vac_pkg::*;
  localparam int P = 400;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0] din_pin = 8'h07;
  logic fault_pin = 1'b0;
  logic [9:0] adc_a = 10'h000;
  logic [9:0] adc_b = 10'h000;
  logic sol_a_pwm, sol_b_pwm, dout_err, dout_sol_b;
  logic led_green, led_yellow, led_red, nvm_store;
  logic meas_go = 1'b0;
  logic meas_done;
  logic [15:0] on_a, on_b;
  logic rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'hC86BB0AD;
  int err_count = 0;
  int check_count = 0;
  int store_count = 0;
  int n;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  vac_core #(.PWM_PERIOD(P)) vac_core_inst (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .din_pin, .fault_pin, .adc_a,
    .adc_b, .sol_a_pwm, .sol_b_pwm, .dout_err, .dout_sol_b, .led_green,
    .led_yellow, .led_red, .nvm_store);

  vac_valve_model #(.PERIOD(P)) vac_valve_model_inst (.core_clk, .rst_n,
    .sol_a_pwm, .sol_b_pwm, .meas_go, .meas_done, .on_a, .on_b);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // apply pins, let the pwm settle, then measure one period
  task automatic run(input logic [7:0] d, input logic [9:0] a,
    input logic [9:0] b, input logic [15:0] ea, input logic [15:0] eb);
    int k;
    @(posedge core_clk);
    din_pin <= d;
    adc_a <= a;
    adc_b <= b;
    repeat (2 * P) @(posedge core_clk);
    exp_q.push_back(ea);
    exp_q.push_back(eb);
    meas_go <= 1'b1;
    @(posedge core_clk);
    meas_go <= 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 2 * P)
    begin
      @(posedge core_clk);
      k++;
    end
  endtask : run

  // result watcher: read data and coil measurements against notes
  always @(posedge core_clk)
  begin
    if (rd_d)
      check(reg_rdata, exp_q.pop_front());
    if (meas_done)
    begin
      check(on_a, exp_q.pop_front());
      check(on_b, exp_q.pop_front());
    end
    if (nvm_store === 1'b1)
      store_count++;
    rd_d <= reg_rd;
  end

  // watchdog
  initial
  begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check(16'(led_green), 16'h0001);
    rd(REG_MODE, 16'h0000);
    rd(REG_IMIN, 16'h0096);
    rd(REG_IMAX, 16'h02BC);
    rd(REG_DFREQ, 16'h0064);
    rd(REG_DLVL, 16'h0064);
    rd(REG_RAMP, 16'h0000);
    wr(4'h8, 16'hFFFF);
    rd(4'h8, 16'h0000);
    $display("test reset_values done");
    wr(REG_IMIN, 16'hFFFF);
    rd(REG_IMIN, 16'h03B6);
    rd(REG_IMAX, 16'h03B6);
    wr(REG_IMAX, 16'hFFFF);
    rd(REG_IMAX, 16'h0708);
    wr(REG_IMIN, 16'h00C8);
    wr(REG_IMAX, 16'h0064);
    rd(REG_IMAX, 16'h00C8);
    wr(REG_DFREQ, 16'h0000);
    rd(REG_DFREQ, 16'h0014);
    wr(REG_DLVL, 16'hFFFF);
    rd(REG_DLVL, 16'h00C8);
    rd(REG_DFREQ, 16'h0014);
    wr(REG_IMAX, 16'h03E8);
    wr(REG_DLVL, 16'h0000);
    $display("test clamps done");
    // imin 200 mA = 40 cycles, imax 1000 mA = 200 cycles of 400
    run(8'h07, 10'h000, 10'h000, 16'd40, 16'd0);
    run(8'h07, 10'h200, 10'h000, 16'd120, 16'd0);
    run(8'h07, 10'h3FF, 10'h000, 16'd200, 16'd0);
    check(16'(dout_sol_b), 16'h0000);
    run(8'h0F, 10'h3FF, 10'h000, 16'd0, 16'd200);
    check(16'(dout_sol_b), 16'h0001);
    check(16'(led_yellow), 16'h0001);
    run(8'h06, 10'h3FF, 10'h000, 16'd0, 16'd0);
    run(8'h0D, 10'h3FF, 10'h000, 16'd0, 16'd0);
    run(8'h0B, 10'h3FF, 10'h3FF, 16'd0, 16'd0);
    $display("test single_mode done");
    wr(REG_MODE, 16'h0001);
    run(8'h0F, 10'h3FF, 10'h000, 16'd200, 16'd0);
    run(8'h07, 10'h000, 10'h000, 16'd0, 16'd200);
    wr(REG_MODE, 16'h0002);
    run(8'h07, 10'h000, 10'h000, 16'd0, 16'd200);
    run(8'h07, 10'h3FF, 10'h000, 16'd200, 16'd0);
    wr(REG_MODE, 16'h0003);
    rd(REG_MODE, 16'h0003);
    run(8'h07, 10'h3FF, 10'h000, 16'd200, 16'd40);
    run(8'h07, 10'h000, 10'h3FF, 16'd40, 16'd200);
    $display("test modes done");
    wr(REG_MODE, 16'h0000);
    for (int k = 1; k < 8; k++)
      wr(4'(REG_FIX_BASE + k), 16'(128 * k));
    rd(4'h9, 16'h0080);
    for (int k = 1; k < 8; k++)
    begin
      seed = xs(seed);
      run({3'(k), 5'h07}, seed[9:0], seed[19:10], 16'(40 + 20 * k),
        16'd0);
    end
    $display("test fixed_presets done");
    wr(REG_RAMP, 16'h03E8);
    rd(REG_RAMP, 16'h03E8);
    run(8'h17, 10'h3FF, 10'h000, 16'd200, 16'd0);
    wr(REG_RAMP, 16'h0000);
    $display("test ramp_bypass done");
    @(posedge core_clk);
    fault_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(16'(dout_err), 16'h0001);
    check(16'(led_red), 16'h0001);
    rd(REG_STATUS, 16'h0317);
    fault_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(16'(dout_err), 16'h0000);
    n = store_count;
    wr(REG_CTRL, 16'h0000);
    wr(REG_CTRL, 16'h0001);
    repeat (4) @(posedge core_clk);
    check(16'(store_count - n), 16'h0001);
    $display("test error_store done");
    repeat (4) @(posedge core_clk);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
